/* File: core/asil_defines.svh */
// constants for the shared interrupt request logic of an expansion adapter
// assumes a 10 MHz adapter clock and an 11-bit channel address decode
`ifndef ASIL_DEFINES_SVH
`define ASIL_DEFINES_SVH

// ----------------------------------------------------------------------
// clock and pulse timing
// ----------------------------------------------------------------------
`define ASIL_CLK_PERIOD_NS  100
`define ASIL_PULSE_MIN_NS   125
`define ASIL_PULSE_MAX_NS   1000
`define ASIL_PULSE_MIN_CYC  ((`ASIL_PULSE_MIN_NS + `ASIL_CLK_PERIOD_NS - 1) / `ASIL_CLK_PERIOD_NS)
`define ASIL_PULSE_MAX_CYC  (`ASIL_PULSE_MAX_NS / `ASIL_CLK_PERIOD_NS)
`define ASIL_PULSE_DEF_CYC  (`ASIL_PULSE_MIN_CYC + 1)

// ----------------------------------------------------------------------
// level re-arm strobe addresses
// ----------------------------------------------------------------------
`define ASIL_ADDR_W         11
`define ASIL_LEVEL3_REARM   11'h2F3
`define ASIL_LEVEL4_REARM   11'h2F4
`define ASIL_LEVEL5_REARM   11'h2F5
`define ASIL_LEVEL6_REARM   11'h2F6
`define ASIL_LEVEL7_REARM   11'h2F7
`define ASIL_LEVEL9_REARM   11'h2F2
`define ASIL_LEVEL10_REARM  11'h6F2
`define ASIL_LEVEL11_REARM  11'h6F3
`define ASIL_LEVEL12_REARM  11'h6F4
`define ASIL_LEVEL14_REARM  11'h6F6
`define ASIL_LEVEL15_REARM  11'h6F7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ASIL_STATUS_RST     1'b0
`define ASIL_ENABLE_RST     1'b0
`define ASIL_BUSY_RST       1'b0
// pin synchroniser order {sa, aen, iow_n, reset_drv, irq_line}
`define ASIL_SYNC_W         15
`define ASIL_SYNC_RST       15'h0006

`endif

/* File: core/asil_pkg.sv */
// types shared by the shared interrupt request logic
// assumes asil_defines.svh supplies all numeric constants
package asil_pkg;
    typedef logic [3:0] asil_level_t;
    typedef enum logic {ASIL_NONSHARED, ASIL_SHARED} asil_mode_t;
    typedef enum logic [1:0] {ASIL_PT_IDLE, ASIL_PT_LOW, ASIL_PT_END} asil_pt_state_t;
endpackage

/* File: core/asil_pulse_timer.sv */
// fixed-width low pulse timer for the shared request line
// assumes start_i is a one-cycle request on the same clock
`timescale 1ns/1ns
`include "asil_defines.svh"
module asil_pulse_timer #(
    parameter int unsigned WIDTH_CYC = `ASIL_PULSE_DEF_CYC
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic start_i,
    output logic      active_o,
    output logic      done_o
);
    import asil_pkg::*;

    asil_pt_state_t state_reg;
    asil_pt_state_t state_next;
    logic [7:0]     cnt_reg;
    logic [7:0]     cnt_next;
    wire  logic     last_cyc = (cnt_reg == 8'(WIDTH_CYC - 1));

    // ------------------------------------------------------------------
    // pulse sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            ASIL_PT_IDLE: begin
                cnt_next = 8'h00;
                if (start_i) begin
                    state_next = ASIL_PT_LOW;
                end
            end
            ASIL_PT_LOW: begin
                cnt_next = cnt_reg + 8'h01;
                if (last_cyc) begin
                    state_next = ASIL_PT_END;
                end
            end
            default: begin
                state_next = ASIL_PT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ASIL_PT_IDLE;
            cnt_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign active_o = (state_reg == ASIL_PT_LOW);
    assign done_o   = (state_reg == ASIL_PT_END);
endmodule

/* File: core/asil_top.sv */
// adapter side interrupt request logic, nonshared and shared modes
// assumes channel pins arrive asynchronously; software latch access is
// by plain strobes from the adapter's own register logic on CLK_I
//
// Summary of operation
// - one-bit status latch, written and read back, shows a pending interrupt.
// - one-bit enable latch, written and read back, gates the request line.
// - channel reset drive clears both latches and idles the line driver.
// - nonshared line idles low, goes high and holds until serviced.
// - nonshared line returns low when service clears the adapter.
// - shared request is one low pulse of 125 to 1000 ns, then release.
// - status latch is set no later than the start of the pulse.
// - pulse starts only on status and enable with the level idle.
// - any pulse on the level inhibits every adapter until the re-arm write.
// - a pending request pulses right after the re-arm write ends.
// - each level has one common re-arm address, 2F2-2F7 and 6F2-6F7.
// - re-arm decode uses address bits 0 to 10, write strobe and address enable.
// - re-arm strobe or channel reset clears the level inhibit.
// - the re-arm write looks at no data.
`timescale 1ns/1ns
`include "asil_defines.svh"
module asil_top #(
    parameter int unsigned PULSE_CYC = `ASIL_PULSE_DEF_CYC
) (
    input  wire logic                     CLK_I,
    input  wire logic                     RSTN_I,
    input  wire logic                     RESET_DRV_I,
    input  wire logic [`ASIL_ADDR_W-1:0]  SA_I,
    input  wire logic                     IOW_N_I,
    input  wire logic                     AEN_I,
    input  wire logic                     IRQ_I,
    input  wire asil_pkg::asil_level_t    LEVEL_I,
    input  wire asil_pkg::asil_mode_t     MODE_I,
    input  wire logic                     SRV_REQ_I,
    input  wire logic                     STAT_WR_I,
    input  wire logic                     STAT_WDATA_I,
    input  wire logic                     EN_WR_I,
    input  wire logic                     EN_WDATA_I,
    output logic                          STAT_O,
    output logic                          EN_O,
    output logic                          IRQ_O,
    output logic                          IRQ_OE_O,
    output logic                          LEVEL_BUSY_O
);
    import asil_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [`ASIL_SYNC_W-1:0] s1_reg;
    logic [`ASIL_SYNC_W-1:0] s2_reg;
    logic [`ASIL_SYNC_W-1:0] s3_reg;
    logic [`ASIL_SYNC_W-1:0] pin_reg;
    logic [`ASIL_SYNC_W-1:0] pin_next;
    wire  logic [`ASIL_SYNC_W-1:0] pin_raw = {SA_I, AEN_I, IOW_N_I, RESET_DRV_I, IRQ_I};
    wire  logic [`ASIL_SYNC_W-1:0] pin_agree = ~(s2_reg ^ s3_reg);

    // a bit changes only once stages two and three agree
    assign pin_next = (pin_agree & s3_reg) | (~pin_agree & pin_reg);

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            s1_reg  <= `ASIL_SYNC_RST;
            s2_reg  <= `ASIL_SYNC_RST;
            s3_reg  <= `ASIL_SYNC_RST;
            pin_reg <= `ASIL_SYNC_RST;
        end else begin
            s1_reg  <= pin_raw;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            pin_reg <= pin_next;
        end
    end

    wire logic [`ASIL_ADDR_W-1:0] sa_f = pin_reg[`ASIL_SYNC_W-1:4];
    wire logic aen_f      = pin_reg[3];
    wire logic iow_n_f    = pin_reg[2];
    wire logic chan_rst   = pin_reg[1];
    wire logic irq_line_f = pin_reg[0];

    // ------------------------------------------------------------------
    // re-arm strobe decode
    // ------------------------------------------------------------------
    logic [`ASIL_ADDR_W-1:0] rearm_addr;
    logic                    rearm_valid;
    logic                    armed_reg;
    logic                    armed_next;
    logic                    iow_n_d_reg;

    // one common address per level
    always_comb begin
        rearm_valid = 1'b1;
        case (LEVEL_I)
            4'h3:    rearm_addr = `ASIL_LEVEL3_REARM;
            4'h4:    rearm_addr = `ASIL_LEVEL4_REARM;
            4'h5:    rearm_addr = `ASIL_LEVEL5_REARM;
            4'h6:    rearm_addr = `ASIL_LEVEL6_REARM;
            4'h7:    rearm_addr = `ASIL_LEVEL7_REARM;
            4'h9:    rearm_addr = `ASIL_LEVEL9_REARM;
            4'hA:    rearm_addr = `ASIL_LEVEL10_REARM;
            4'hB:    rearm_addr = `ASIL_LEVEL11_REARM;
            4'hC:    rearm_addr = `ASIL_LEVEL12_REARM;
            4'hE:    rearm_addr = `ASIL_LEVEL14_REARM;
            4'hF:    rearm_addr = `ASIL_LEVEL15_REARM;
            default: begin
                rearm_addr  = `ASIL_ADDR_W'h000;
                rearm_valid = 1'b0;
            end
        endcase
    end

    // only bits 0..10 compared, qualified by write strobe and processor cycle
    wire logic addr_hit  = rearm_valid && (sa_f == rearm_addr);
    wire logic iow_hit   = addr_hit && !iow_n_f && !aen_f;
    wire logic iow_rise  = iow_n_f && !iow_n_d_reg;
    // strobe fires on the trailing edge; the data bus is never looked at
    wire logic rearm     = armed_reg && iow_rise;

    assign armed_next = iow_hit ? 1'b1 : (iow_rise ? 1'b0 : armed_reg);

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            armed_reg   <= 1'b0;
            iow_n_d_reg <= 1'b1;
        end else begin
            armed_reg   <= armed_next;
            iow_n_d_reg <= iow_n_f;
        end
    end

    // ------------------------------------------------------------------
    // status and enable latches
    // ------------------------------------------------------------------
    logic stat_reg;
    logic stat_next;
    logic en_reg;
    logic en_next;

    always_comb begin
        stat_next = stat_reg;
        en_next   = en_reg;
        if (chan_rst) begin
            stat_next = `ASIL_STATUS_RST;
            en_next   = `ASIL_ENABLE_RST;
        end else begin
            if (STAT_WR_I) begin
                stat_next = STAT_WDATA_I;
            end
            // a service request beats a software clear in the same cycle
            if (SRV_REQ_I) begin
                stat_next = 1'b1;
            end
            if (EN_WR_I) begin
                en_next = EN_WDATA_I;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            stat_reg <= `ASIL_STATUS_RST;
            en_reg   <= `ASIL_ENABLE_RST;
        end else begin
            stat_reg <= stat_next;
            en_reg   <= en_next;
        end
    end

    // ------------------------------------------------------------------
    // level inhibit and pulse generator
    // ------------------------------------------------------------------
    logic busy_reg;
    logic busy_next;
    logic pulse_act;
    logic pulse_done;
    wire  logic shared_mode = (MODE_I == ASIL_SHARED);
    wire  logic req_live    = stat_reg && en_reg;
    wire  logic pulse_start = shared_mode && req_live && !busy_reg
                              && !pulse_act && !pulse_done && !chan_rst;
    // any low level seen on the shared line, ours or another adapter's
    wire  logic line_seen   = shared_mode && (pulse_start || !irq_line_f);

    // setting wins over the re-arm clear
    assign busy_next = line_seen ? 1'b1 :
                       ((rearm || chan_rst) ? 1'b0 : busy_reg);

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            busy_reg <= `ASIL_BUSY_RST;
        end else begin
            busy_reg <= busy_next;
        end
    end

    asil_pulse_timer #(
        .WIDTH_CYC (PULSE_CYC)
    ) u_pulse (
        .clk_i    (CLK_I),
        .rstn_i   (RSTN_I),
        .start_i  (pulse_start),
        .active_o (pulse_act),
        .done_o   (pulse_done)
    );

    // ------------------------------------------------------------------
    // request line driver
    // ------------------------------------------------------------------
    logic irq_reg;
    logic irq_next;
    logic oe_reg;
    logic oe_next;

    always_comb begin
        if (chan_rst) begin
            irq_next = 1'b0;
            oe_next  = 1'b0;
        end else if (shared_mode) begin
            irq_next = 1'b0;
            oe_next  = pulse_act;
        end else begin
            irq_next = stat_reg;
            oe_next  = en_reg;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end else begin
            irq_reg <= irq_next;
            oe_reg  <= oe_next;
        end
    end

    assign IRQ_O        = irq_reg;
    assign IRQ_OE_O     = oe_reg;
    assign STAT_O       = stat_reg;
    assign EN_O         = en_reg;
    assign LEVEL_BUSY_O = busy_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [7:0] low_len_reg;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            low_len_reg <= 8'h00;
        end else if (oe_reg && !irq_reg && shared_mode) begin
            low_len_reg <= low_len_reg + 8'h01;
        end else begin
            low_len_reg <= 8'h00;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    a_status_set: assert property (
        SRV_REQ_I && !chan_rst |=> STAT_O)
        else $error("service request did not set status");
    a_enable_write: assert property (
        EN_WR_I && !chan_rst |=> EN_O == $past(EN_WDATA_I))
        else $error("enable latch did not take written value");
    a_chan_reset: assert property (
        chan_rst |=> !STAT_O && !EN_O && !IRQ_OE_O)
        else $error("channel reset left latch or driver active");
    a_nonshared_hold: assert property (
        !shared_mode && en_reg && stat_reg && !chan_rst |=> IRQ_OE_O && IRQ_O)
        else $error("nonshared request not held high");
    a_nonshared_clear: assert property (
        !shared_mode && en_reg && !stat_reg && !chan_rst |=> IRQ_OE_O && !IRQ_O)
        else $error("nonshared line not low after clear");
    a_pulse_width: assert property (
        $fell(IRQ_OE_O && !IRQ_O) && shared_mode
        |-> low_len_reg >= 8'(`ASIL_PULSE_MIN_CYC)
            && low_len_reg <= 8'(`ASIL_PULSE_MAX_CYC))
        else $error("shared pulse width out of range");
    a_status_first: assert property (
        $rose(pulse_act) |-> $past(stat_reg))
        else $error("pulse started without status set");
    a_start_gate: assert property (
        shared_mode && $past(shared_mode) && $rose(IRQ_OE_O)
        |-> $past(STAT_O, 2) && $past(EN_O, 2) && !$past(LEVEL_BUSY_O, 2))
        else $error("pulse started while gated off");
    a_level_inhibit: assert property (
        pulse_start |=> busy_reg [*2])
        else $error("level not inhibited after pulse");
    a_rearm_pulse: assert property (
        rearm && shared_mode && req_live && !pulse_act && !pulse_done && !chan_rst
        && !STAT_WR_I && !EN_WR_I |-> ##[1:3] pulse_act)
        else $error("pending request did not pulse after re-arm");
    a_rearm_decode: assert property (
        $rose(armed_reg) |-> $past(addr_hit && !iow_n_f && !aen_f))
        else $error("re-arm armed without matching write");
    a_rearm_clear: assert property (
        (rearm || chan_rst) && !line_seen |=> !busy_reg)
        else $error("level inhibit not cleared");

    c_shared_pulse: cover property (pulse_start ##1 pulse_act);
    c_rearm_repulse: cover property (rearm ##[1:3] pulse_start);
    c_nonshared_req: cover property (!shared_mode && $rose(IRQ_O) && IRQ_OE_O);
    c_other_adapter: cover property (shared_mode && !busy_reg && !irq_line_f && !pulse_act);
endmodule

/* File: tb/asil_chan_model.sv */
// channel side model: re-arm writes, channel reset, wired request line
// assumes one adapter under test and a second adapter that only pulses
`timescale 1ns/1ns
module asil_chan_model (
    input  wire logic        clk_i,
    input  wire logic        shared_i,
    input  wire logic        irq_i,
    input  wire logic        irq_oe_i,
    output logic [10:0]      sa_o,
    output logic             iow_n_o,
    output logic             aen_o,
    output logic             reset_drv_o,
    output logic             line_o,
    output logic [6:0]       n_pulse_o,
    output logic [3:0]       width_o
);
    logic       other_low;
    logic [3:0] low_cnt;
    wire        own_low = irq_oe_i & ~irq_i;
    event       pulse_done;
    // -------------------------------------------------------------
    // wired line with pull-up; only one nonshared driver on it
    // -------------------------------------------------------------
    assign line_o = other_low ? 1'b0 : (irq_oe_i ? irq_i : 1'b1);
    initial begin
        sa_o = 11'h000;
        iow_n_o = 1'b1;
        aen_o = 1'b1;
        reset_drv_o = 1'b0;
        other_low = 1'b0;
        n_pulse_o = 7'h00;
        width_o = 4'h0;
        low_cnt = 4'h0;
    end
    // request counted at the rising end of the low pulse
    always @(posedge clk_i) begin
        if (shared_i && own_low) begin
            low_cnt <= low_cnt + 4'h1;
        end else if (low_cnt != 4'h0) begin
            width_o <= low_cnt;
            n_pulse_o <= n_pulse_o + 7'h01;
            low_cnt <= 4'h0;
            -> pulse_done;
        end
    end
    // address-only write; the adapter sees no data
    task automatic rearm(input logic [10:0] addr, input logic aen);
        @(posedge clk_i);
        sa_o <= addr;
        aen_o <= aen;
        repeat (2) @(posedge clk_i);
        iow_n_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        iow_n_o <= 1'b1;
        @(posedge clk_i);
        sa_o <= ~addr;
        aen_o <= 1'b1;
    endtask
    // second shared adapter sends one 300 ns pulse
    task automatic other_pulse();
        @(posedge clk_i);
        other_low <= 1'b1;
        repeat (3) @(posedge clk_i);
        other_low <= 1'b0;
    endtask
    task automatic chan_reset(input logic v);
        @(posedge clk_i);
        reset_drv_o <= v;
    endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the adapter interrupt request logic
// assumes the channel model drives the pins and resolves the line
`timescale 1ns/1ns
module tb;
    import asil_pkg::*;
    localparam int unsigned PCYC = 4;
    localparam logic [3:0]  LV [11] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9,
                                        4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
    localparam logic [10:0] AD [11] = '{11'h2F3, 11'h2F4, 11'h2F5, 11'h2F6,
        11'h2F7, 11'h2F2, 11'h6F2, 11'h6F3, 11'h6F4, 11'h6F6, 11'h6F7};
    logic        clk = 1'b0;
    logic        rstn;
    logic        srv_req;
    logic        stat_wr;
    logic        stat_wdata;
    logic        en_wr;
    logic        en_wdata;
    asil_level_t level;
    asil_mode_t  mode;
    logic [10:0] sa;
    logic        iow_n;
    logic        aen;
    logic        reset_drv;
    logic        line;
    logic        stat;
    logic        en;
    logic        irq;
    logic        irq_oe;
    logic        busy;
    logic [6:0]  n_pulse;
    logic [3:0]  width;
    logic [6:0]  npx = 7'h00;
    logic        s;
    logic        e;
    logic [11:0] st_q [$];
    logic [3:0]  pw_q [$];
    event        look_ev;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    // -------------------------------------------------------------
    // design, channel model, clock
    // -------------------------------------------------------------
    asil_top #(.PULSE_CYC(PCYC)) i_asil_top (
        .CLK_I(clk), .RSTN_I(rstn), .RESET_DRV_I(reset_drv), .SA_I(sa),
        .IOW_N_I(iow_n), .AEN_I(aen), .IRQ_I(line), .LEVEL_I(level),
        .MODE_I(mode), .SRV_REQ_I(srv_req), .STAT_WR_I(stat_wr),
        .STAT_WDATA_I(stat_wdata), .EN_WR_I(en_wr), .EN_WDATA_I(en_wdata),
        .STAT_O(stat), .EN_O(en), .IRQ_O(irq), .IRQ_OE_O(irq_oe),
        .LEVEL_BUSY_O(busy));
    asil_chan_model i_asil_chan_model (
        .clk_i(clk), .shared_i(mode == ASIL_SHARED), .irq_i(irq),
        .irq_oe_i(irq_oe), .sa_o(sa), .iow_n_o(iow_n), .aen_o(aen),
        .reset_drv_o(reset_drv), .line_o(line), .n_pulse_o(n_pulse),
        .width_o(width));
    always #50 clk = ~clk;
    // -------------------------------------------------------------
    // checking
    // -------------------------------------------------------------
    task automatic cmp(input logic [11:0] x, input logic [11:0] g);
        samples_checked++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic look(input logic [4:0] x);
        @(negedge clk);
        st_q.push_back({npx, x});
        -> look_ev;
    endtask
    always @(look_ev) cmp(st_q.pop_front(), {n_pulse, stat, en, line, irq_oe, busy});
    always begin
        @(i_asil_chan_model.pulse_done);
        #1;
        cmp({8'h00, (pw_q.size() > 0) ? pw_q.pop_front() : 4'h0}, {8'h00, width});
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // software latch access: status write, enable write, service request
    task automatic wr(input logic ws, input logic sd, input logic we, input logic ed,
                      input logic rq);
        @(posedge clk);
        stat_wr <= ws;
        stat_wdata <= sd;
        en_wr <= we;
        en_wdata <= ed;
        srv_req <= rq;
        @(posedge clk);
        stat_wr <= 1'b0;
        en_wr <= 1'b0;
        srv_req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic own_pulse();
        pw_q.push_back(4'(PCYC));
        npx = npx + 7'h01;
    endtask
    // -------------------------------------------------------------
    // tests
    // -------------------------------------------------------------
    initial begin
        {rstn, srv_req, stat_wr, stat_wdata, en_wr, en_wdata} = 6'h00;
        level = 4'h3;
        mode = ASIL_NONSHARED;
        void'($urandom(2));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        look(5'b00100);
        for (int i = 0; i < 8; i++) begin
            s = 1'($urandom);
            e = 1'($urandom);
            wr(1'b1, s, 1'b1, e, 1'b0);
            look({s, e, e ? s : 1'b1, e, 1'b0});
        end
        wr(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        look(5'b11110);
        wr(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        look(5'b11110);
        wr(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        look(5'b01010);
        // level masked at the controller while this adapter is disabled
        wr(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        $display("test nonshared done");
        @(posedge clk);
        mode <= ASIL_SHARED;
        i_asil_chan_model.rearm(11'h2F3, 1'b0);
        // strobe reaches the inhibit only after the pin synchroniser
        repeat (4) @(posedge clk);
        wr(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        look(5'b01100);
        own_pulse();
        wr(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        repeat (PCYC + 8) @(posedge clk);
        look(5'b11101);
        wr(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        wr(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        repeat (20) @(posedge clk);
        look(5'b11101);
        i_asil_chan_model.rearm(11'h6F3, 1'b0);
        repeat (12) @(posedge clk);
        look(5'b11101);
        i_asil_chan_model.rearm(11'h2F3, 1'b1);
        repeat (12) @(posedge clk);
        look(5'b11101);
        own_pulse();
        i_asil_chan_model.rearm(11'h2F3, 1'b0);
        repeat (PCYC + 14) @(posedge clk);
        look(5'b11101);
        wr(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        $display("test shared pulse done");
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            level <= LV[i];
            i_asil_chan_model.rearm(AD[(i + 1) % 11], 1'b0);
            repeat (10) @(posedge clk);
            look(5'b01101);
            i_asil_chan_model.rearm(AD[i], 1'b0);
            repeat (10) @(posedge clk);
            look(5'b01100);
            i_asil_chan_model.other_pulse();
            repeat (8) @(posedge clk);
            look(5'b01101);
        end
        // an unlisted level must never decode, not even address zero
        @(posedge clk);
        level <= 4'h8;
        i_asil_chan_model.rearm(11'h000, 1'b0);
        repeat (10) @(posedge clk);
        look(5'b01101);
        $display("test level table done");
        i_asil_chan_model.chan_reset(1'b1);
        repeat (6) @(posedge clk);
        wr(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        look(5'b00100);
        i_asil_chan_model.chan_reset(1'b0);
        repeat (8) @(posedge clk);
        look(5'b00100);
        $display("test channel reset done");
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule
